//--- src/xps_addr_map.sv
// combinational decoder: 24-bit cpu address to access target
// assumes select bits already carry the emulation override
`timescale 1ns/10ps
`default_nettype none
`include "xps_regs.svh"
module xps_addr_map
   import xps_pkg::*;
(
   input  wire logic [23:0] addr,     // cpu address
   xps_sel_if.dst           sel,      // effective enables
   output var  xps_target_e target    // decoded target
);
   logic inLow, inHigh, inM1, inM2, inClk, anyMod;
   // range compares
   assign inLow  = (addr >= `XPS_LOWRAM_LO)  && (addr <= `XPS_LOWRAM_HI);
   assign inHigh = (addr >= `XPS_HIGHRAM_LO) && (addr <= `XPS_HIGHRAM_HI);
   assign inM1   = (addr >= `XPS_MOD1_LO)    && (addr <= `XPS_MOD1_HI);
   assign inM2   = (addr >= `XPS_MOD2_LO)    && (addr <= `XPS_MOD2_HI);
   assign inClk  = (addr >= `XPS_CLK_LO)     && (addr <= `XPS_CLK_HI);
   assign anyMod = sel.effSel[`XPS_BIT_MOD1] | sel.effSel[`XPS_BIT_MOD2];
   // a module range with its own enable clear stays claimed (no external) while the other is on
   always_comb begin
      target = XPS_TGT_EXT;                                                         // R2 R4
      if (sel.globalEn) begin
         if (inLow && sel.effSel[`XPS_BIT_LOWRAM])        target = XPS_TGT_LOWRAM;  // R1
         else if (inHigh && sel.effSel[`XPS_BIT_HIGHRAM]) target = XPS_TGT_HIGHRAM; // R3
         else if (inM1 && sel.effSel[`XPS_BIT_MOD1])      target = XPS_TGT_MOD1;    // R7
         else if (inM2 && sel.effSel[`XPS_BIT_MOD2])      target = XPS_TGT_MOD2;    // R8
         else if ((inM1 || inM2) && anyMod)               target = XPS_TGT_CLOCK;   // R10 R11
         else if (inClk && (sel.effSel[`XPS_BIT_CLOCK] || anyMod))
            target = XPS_TGT_CLOCK;                                                 // R12
      end
   end
endmodule : xps_addr_map
`default_nettype wire

//--- src/xps_periph_select.sv
// peripheral select decoder top: wishbone registers, address decode, access steering
// assumes a cpu access port of one request at a time, held until done
// Behaviour
// R1 - low ram area decoded at E000-E7FF when global and low enable set
// R2 - low ram range goes external when either enable is clear
// R3 - high ram area decoded at C000-DFFF when global and high enable set
// R4 - high ram range goes external when either enable is clear
// R5 - extension ram: 16-bit, zero waits, byte and word accesses
// R6 - extension ram not bit addressable, not stack or register bank
// R7 - first module at EF00-EFFF when global enable and bit 0 set
// R8 - second module at EE00-EEFF when global enable and bit 1 set
// R9 - module accesses: 16-bit, byte allowed, two wait states
// R10 - disabled modules free their port pins; module range external only both off
// R11 - both module enables clear sends EE00-EFFF external
// R12 - clock off goes external; EC00-ECFF external only when both modules off
// R13 - select register resets to 05h
// R14 - select register frozen once global enable is set
// R15 - disabled before global enable: claims no space, pins or interrupts
// R16 - emulation mode reads all select bits set and enables all
// R17 - clock disabled stops oscillator in power-down; else osc select decides
// R18 - one 16 MB space, every location byte or word accessible
// R19 - module in use limits segment lines to four
// R20 - writes after global enable are silently ignored; the code still applies config writes of emulation, power-down and osc-off
`timescale 1ns/10ps
`default_nettype none
`include "xps_regs.svh"
module xps_periph_select
   import xps_pkg::*;
(
   input  wire logic        sys_clk,      // 20 MHz clock
   input  wire logic        rst,          // sync reset, high
   // classic wishbone slave
   input  wire logic        wb_cyc_i,     // cycle
   input  wire logic        wb_stb_i,     // strobe
   input  wire logic        wb_we_i,      // write enable
   input  wire logic [15:0] wb_adr_i,     // byte address
   input  wire logic [3:0]  wb_sel_i,     // byte lanes
   input  wire logic [31:0] wb_dat_i,     // write data
   output logic      [31:0] wb_dat_o,     // read data
   output logic             wb_ack_o,     // acknowledge
   output logic             wb_err_o,     // unmapped address
   // cpu access port
   input  wire logic        cpuReq,       // access request, held until cpuDone
   input  wire logic [23:0] cpuAddr,      // byte address in 16 MB space
   input  wire logic        cpuWrite,     // write access
   input  wire logic        cpuByte,      // byte (not word) access
   input  wire logic        cpuBitOp,     // bit-addressed access
   input  wire logic        cpuStack,     // stack or register bank access
   output logic             cpuDone,      // one-cycle completion
   output logic             cpuErr,       // refused access, with cpuDone
   // steering outputs, valid during an access
   output logic [2:0]       accTarget,    // target code
   output logic             selLowRam,    // low ram area select
   output logic             selHighRam,   // high ram area select
   output logic             selMod1,      // first bus module select
   output logic             selMod2,      // second bus module select
   output logic             selClock,     // clock calendar select
   output logic             selExt,       // external interface select
   output logic [1:0]       byteEn,       // byte lanes of access
   // pin and power side
   output logic [3:0]       portPinFree,  // port 4 pins 4..7 free for gpio
   output logic             segLimit,     // only four segment lines
   output logic             oscStop       // clock oscillator stopped
);
   // ******************************************
   // state
   // ******************************************
   typedef struct packed {
      logic [4:0]  selReg;
      logic        globalEn;
      logic        emuMode;
      logic        powerDown;
      logic        oscOff;
      logic        ack;
      logic        err;
      logic [31:0] rdata;
      xps_state_e  phase;
      logic [2:0]  tgt;
      logic        done;
      logic        cerr;
      logic [5:0]  sels;
      logic [1:0]  be;
      logic [3:0]  pins;
      logic        seg;
      logic        osc;
   } xps_top_s;
   xps_top_s st, next_st;
   logic        wbHit;
   logic [4:0]  effSelV;
   xps_target_e tgtNow;
   logic        waitDone;
   logic [1:0]  waitCnt;
   logic        waitStart;
   logic        refuse;
   xps_sel_if   selBus();
   // emulation forces every select bit set
   assign effSelV         = st.emuMode ? 5'h1F : st.selReg;   // R16
   assign selBus.effSel   = effSelV;
   assign selBus.globalEn = st.globalEn;
   // ******************************************
   // address decode and wait states
   // ******************************************
   xps_addr_map u_map (
      .addr   (cpuAddr),
      .sel    (selBus),
      .target (tgtNow)
   );
   // modules get two waits, ram none; external waits are the bus controller's
   always_comb begin
      waitCnt = 2'(`XPS_RAM_WAIT);                           // R5
      if (tgtNow == XPS_TGT_MOD1 || tgtNow == XPS_TGT_MOD2)
         waitCnt = 2'(`XPS_MOD_WAIT);                         // R9
   end
   // ram is not bit addressable nor usable as stack or register bank
   assign refuse = (cpuBitOp || cpuStack) &&
                   (tgtNow == XPS_TGT_LOWRAM || tgtNow == XPS_TGT_HIGHRAM);   // R6
   assign waitStart = cpuReq && (st.phase == XPS_ST_IDLE) && !refuse;
   xps_wait_gen #(.WW(2)) u_wait (
      .sys_clk (sys_clk),
      .rst     (rst),
      .start   (waitStart),
      .waits   (waitCnt),
      .done    (waitDone)
   );
   assign wbHit = (wb_adr_i == `XPS_SEL_OFS) || (wb_adr_i == `XPS_CFG_OFS) ||
                  (wb_adr_i == `XPS_STAT_OFS);
   // ******************************************
   // next state
   // ******************************************
   always_comb begin
      next_st      = st;
      next_st.ack  = 1'b0;
      next_st.err  = 1'b0;
      next_st.done = 1'b0;
      next_st.cerr = 1'b0;
      // wishbone: answer one cycle after strobe, drop in the next
      if (wb_cyc_i && wb_stb_i && !st.ack && !st.err) begin
         next_st.ack = wbHit;
         next_st.err = !wbHit;
         next_st.rdata = '0;
         if (wb_adr_i == `XPS_SEL_OFS) begin
            next_st.rdata[4:0] = effSelV;                     // R16
            if (wb_we_i && wb_sel_i[0] && !st.globalEn)       // R14 R20
               next_st.selReg = wb_dat_i[4:0];
         end else if (wb_adr_i == `XPS_CFG_OFS) begin
            next_st.rdata[`XPS_CFG_GLOBAL] = st.globalEn;
            next_st.rdata[`XPS_CFG_EMU]    = st.emuMode;
            next_st.rdata[`XPS_CFG_PDN]    = st.powerDown;
            next_st.rdata[`XPS_CFG_OSCOFF] = st.oscOff;
            if (wb_we_i && wb_sel_i[0]) begin
               // global enable is set-once: software cannot clear it before reset
               next_st.globalEn = st.globalEn | wb_dat_i[`XPS_CFG_GLOBAL];
               next_st.emuMode  = wb_dat_i[`XPS_CFG_EMU];
               next_st.powerDown= wb_dat_i[`XPS_CFG_PDN];
               next_st.oscOff   = wb_dat_i[`XPS_CFG_OSCOFF];
            end
         end else if (wb_adr_i == `XPS_STAT_OFS) begin
            next_st.rdata[2:0] = st.tgt;
            next_st.rdata[4:3] = st.phase;
         end
      end
      // cpu access sequencer
      unique case (st.phase)
         XPS_ST_IDLE: begin
            if (cpuReq) begin
               next_st.tgt = tgtNow;
               next_st.be  = cpuByte ? (cpuAddr[0] ? 2'b10 : 2'b01) : 2'b11;   // R18
               next_st.sels = '0;
               if (refuse) begin
                  next_st.done  = 1'b1;
                  next_st.cerr  = 1'b1;
                  next_st.phase = XPS_ST_DONE;
               end else begin
                  unique case (tgtNow)
                     XPS_TGT_LOWRAM:  next_st.sels[0] = 1'b1;   // R1
                     XPS_TGT_HIGHRAM: next_st.sels[1] = 1'b1;   // R3
                     XPS_TGT_MOD1:    next_st.sels[2] = 1'b1;   // R7
                     XPS_TGT_MOD2:    next_st.sels[3] = 1'b1;   // R8
                     XPS_TGT_CLOCK:   next_st.sels[4] = 1'b1;   // R12
                     default:         next_st.sels[5] = 1'b1;   // R2 R4 R11
                  endcase
                  next_st.phase = XPS_ST_WAIT;
               end
            end
         end
         XPS_ST_WAIT: begin
            if (waitDone) begin
               next_st.done  = 1'b1;
               next_st.sels  = '0;
               next_st.phase = XPS_ST_DONE;
            end
         end
         XPS_ST_DONE: begin
            // one idle cycle lets the cpu drop its request
            next_st.sels  = '0;
            next_st.phase = XPS_ST_IDLE;
         end
         default: next_st.phase = XPS_ST_IDLE;
      endcase
      // pins of a disabled module stay free; unclaimed before global enable too
      next_st.pins[0] = !(st.globalEn && effSelV[`XPS_BIT_MOD2]);   // R10 R15
      next_st.pins[1] = !(st.globalEn && effSelV[`XPS_BIT_MOD1]);   // R10 R15
      next_st.pins[2] = next_st.pins[1];
      next_st.pins[3] = next_st.pins[0];
      next_st.seg = st.globalEn &&
                    (effSelV[`XPS_BIT_MOD1] || effSelV[`XPS_BIT_MOD2]);   // R19
      // clock disabled: oscillator off in power-down; enabled: select bit decides
      next_st.osc = st.powerDown &&
                    (!(st.globalEn && effSelV[`XPS_BIT_CLOCK]) || st.oscOff);   // R17
   end
   // ******************************************
   // registers
   // ******************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st        <= '0;
         st.selReg <= 5'(`XPS_SEL_RESET);                       // R13
         st.pins   <= 4'hF;
      end else begin
         st <= next_st;
      end
   end
   // outputs straight from flip-flops
   assign wb_dat_o    = st.rdata;
   assign wb_ack_o    = st.ack;
   assign wb_err_o    = st.err;
   assign cpuDone     = st.done;
   assign cpuErr      = st.cerr;
   assign accTarget   = st.tgt;
   assign selLowRam   = st.sels[0];
   assign selHighRam  = st.sels[1];
   assign selMod1     = st.sels[2];
   assign selMod2     = st.sels[3];
   assign selClock    = st.sels[4];
   assign selExt      = st.sels[5];
   assign byteEn      = st.be;
   assign portPinFree = st.pins;
   assign segLimit    = st.seg;
   assign oscStop     = st.osc;
endmodule : xps_periph_select
`default_nettype wire

//--- src/xps_pkg.sv
// types shared by the peripheral select decoder files
// assumes xps_regs.svh for the numeric constants
package xps_pkg;
   typedef enum logic [2:0] {
      XPS_TGT_EXT     = 3'b000,
      XPS_TGT_LOWRAM  = 3'b001,
      XPS_TGT_HIGHRAM = 3'b010,
      XPS_TGT_MOD1    = 3'b011,
      XPS_TGT_MOD2    = 3'b100,
      XPS_TGT_CLOCK   = 3'b101
   } xps_target_e;
   typedef enum logic [1:0] {
      XPS_ST_IDLE = 2'b00,
      XPS_ST_WAIT = 2'b01,
      XPS_ST_DONE = 2'b10
   } xps_state_e;
endpackage : xps_pkg

//--- src/xps_regs.svh
// offsets, field positions, reset values and address windows of the decoder
// assumes inclusion by bare name from the design files
`ifndef XPS_REGS_SVH
`define XPS_REGS_SVH
`define XPS_SEL_OFS        16'hF024
`define XPS_CFG_OFS        16'hF028
`define XPS_STAT_OFS       16'hF02C
`define XPS_SEL_RESET      16'h0005
`define XPS_BIT_MOD1       0
`define XPS_BIT_MOD2       1
`define XPS_BIT_LOWRAM     2
`define XPS_BIT_HIGHRAM    3
`define XPS_BIT_CLOCK      4
`define XPS_CFG_GLOBAL     0
`define XPS_CFG_EMU        1
`define XPS_CFG_PDN        2
`define XPS_CFG_OSCOFF     3
`define XPS_LOWRAM_LO      24'h00_E000
`define XPS_LOWRAM_HI      24'h00_E7FF
`define XPS_HIGHRAM_LO     24'h00_C000
`define XPS_HIGHRAM_HI     24'h00_DFFF
`define XPS_MOD1_LO        24'h00_EF00
`define XPS_MOD1_HI        24'h00_EFFF
`define XPS_MOD2_LO        24'h00_EE00
`define XPS_MOD2_HI        24'h00_EEFF
`define XPS_CLK_LO         24'h00_EC00
`define XPS_CLK_HI         24'h00_ECFF
`define XPS_RAM_WAIT       0
`define XPS_MOD_WAIT       2
`endif

//--- src/xps_sel_if.sv
// effective select bits handed from the registers to the decoder
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface xps_sel_if;
   logic [4:0] effSel;     // effective enables after emulation override
   logic       globalEn;   // global peripheral bus enable
   modport src (output effSel, output globalEn);
   modport dst (input effSel, input globalEn);
endinterface : xps_sel_if
`default_nettype wire

//--- src/xps_wait_gen.sv
// wait-state counter: holds a done pulse back by a programmed number of cycles
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/10ps
`default_nettype none
module xps_wait_gen #(
   parameter int WW = 2   // width of wait count
) (
   input  wire logic          sys_clk,  // clock
   input  wire logic          rst,      // sync reset, high
   input  wire logic          start,    // begin counting
   input  wire logic [WW-1:0] waits,    // wait states to insert
   output logic               done      // one-cycle completion
);
   typedef struct packed {
      logic          busy;
      logic [WW-1:0] cnt;
      logic          done;
   } xps_wait_s;
   xps_wait_s st, next_st;
   if (WW < 1) $error("WW must be at least one");
   // count down the wait states, then flag completion
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.busy = (waits != '0);
         next_st.cnt  = waits;
         next_st.done = (waits == '0);
      end else if (st.busy) begin
         if (st.cnt == WW'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
         next_st.cnt = st.cnt - WW'(1);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) st <= '0;
      else     st <= next_st;
   end
   assign done = st.done;
endmodule : xps_wait_gen
`default_nettype wire

//--- verification/tb.sv
// self-checking bench of the peripheral select decoder
// assumes the cpu model and the bound checker beside the design
`timescale 1ns/10ps
`default_nettype none
`include "xps_regs.svh"
module tb
   import xps_pkg::*;
;
   logic        sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [3:0]  wb_sel_i = 4'h0, portPinFree;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic        wb_ack_o, wb_err_o, cpuReq, cpuWrite, cpuByte, cpuBitOp, cpuStack, cpuDone;
   logic        cpuErr, selLowRam, selHighRam, selMod1, selMod2, selClock, selExt, segLimit, oscStop;
   logic [23:0] cpuAddr;
   logic [2:0]  accTarget, seenTgt = 3'h7;
   logic [1:0]  byteEn, seenBe;
   int          n_fail = 0, samples_checked = 0, cycles = 0, lat = 0;
   logic [33:0] wq[$], wExp;  // {read, err, data}
   logic [8:0]  cq[$], cExp;  // {target, refused, latency, lanes}
   logic [4:0]  sv[6] = '{5'h05, 5'h1F, 5'h00, 5'h0A, 5'h13, 5'h16};
   logic [23:0] base[7] = '{24'h00_E000, 24'h00_C000, 24'h00_EF00, 24'h00_EE00, 24'h00_EC00,
                            24'h00_E800, 24'h01_0000};
   logic [23:0] span[7] = '{24'h00_07FF, 24'h00_1FFF, 24'h00_00FF, 24'h00_00FF, 24'h00_00FF,
                            24'h00_03FF, 24'h00_FFFF};
   always #25 sys_clk = ~sys_clk;
   xps_periph_select dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cpuReq(cpuReq),
      .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuByte(cpuByte), .cpuBitOp(cpuBitOp),
      .cpuStack(cpuStack), .cpuDone(cpuDone), .cpuErr(cpuErr), .accTarget(accTarget),
      .selLowRam(selLowRam), .selHighRam(selHighRam), .selMod1(selMod1), .selMod2(selMod2),
      .selClock(selClock), .selExt(selExt), .byteEn(byteEn), .portPinFree(portPinFree),
      .segLimit(segLimit), .oscStop(oscStop));
   xps_cpu_model cpu (.sys_clk(sys_clk), .cpuDone(cpuDone), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
      .cpuWrite(cpuWrite), .cpuByte(cpuByte), .cpuBitOp(cpuBitOp), .cpuStack(cpuStack));
   // ******************************************
   // helpers
   // ******************************************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic rst_for(input int n);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst <= 1'b0;
   endtask
   // classic single cycle; the answer is noted first
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e);
      wq.push_back({~w, e, d});
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'hF};
      wb_dat_i <= w ? d : 32'h0000_0000;
      do @(posedge sys_clk); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      wb_dat_i <= ~d;
   endtask
   // expected routing; an unclaimed module or clock range stays internal while a module is on
   function automatic logic [8:0] expc(logic [23:0] a, logic [4:0] s, logic g, logic [3:0] f);
      xps_target_e t;
      logic        r;
      t = XPS_TGT_EXT;
      if (g && a inside {[`XPS_LOWRAM_LO:`XPS_LOWRAM_HI]} && s[2]) t = XPS_TGT_LOWRAM;
      if (g && a inside {[`XPS_HIGHRAM_LO:`XPS_HIGHRAM_HI]} && s[3]) t = XPS_TGT_HIGHRAM;
      if (g && a inside {[`XPS_MOD1_LO:`XPS_MOD1_HI]})
         t = s[0] ? XPS_TGT_MOD1 : s[1] ? XPS_TGT_CLOCK : XPS_TGT_EXT;
      if (g && a inside {[`XPS_MOD2_LO:`XPS_MOD2_HI]})
         t = s[1] ? XPS_TGT_MOD2 : s[0] ? XPS_TGT_CLOCK : XPS_TGT_EXT;
      if (g && a inside {[`XPS_CLK_LO:`XPS_CLK_HI]} && |{s[4], s[1:0]}) t = XPS_TGT_CLOCK;
      r = (f[1] | f[0]) && (t == XPS_TGT_LOWRAM || t == XPS_TGT_HIGHRAM);
      return {t, r, r ? 3'h2 : (t == XPS_TGT_MOD1 || t == XPS_TGT_MOD2) ? 3'h5 : 3'h3,
              f[2] ? {a[0], ~a[0]} : 2'b11};
   endfunction
   task automatic acc(input logic [23:0] a, input logic [4:0] s, input logic g, input logic [3:0] f);
      cq.push_back(expc(a, s, g, f));
      cpu.access(a, f);
   endtask
   // random even word, odd top byte, then a bit access and a stack access
   task automatic sweep(input logic [4:0] s, input logic g);
      for (int k = 0; k < 7; k++) begin
         acc((base[k] + (24'($urandom()) & span[k])) & 24'hFF_FFFE, s, g, 4'($urandom_range(1)) << 3);
         acc(base[k] + span[k], s, g, 4'h4);
      end
      acc(`XPS_LOWRAM_LO, s, g, 4'h6);
      acc(`XPS_HIGHRAM_HI - 24'h00_0001, s, g, 4'h9);
   endtask
   // ******************************************
   // watcher and tests
   // ******************************************
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         results();
      end
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
         wExp = wq.pop_front();
         check("wb error", wb_err_o, wExp[32]);
         if (wExp[33]) check("wb read data", wb_dat_o, wExp[31:0]);
      end
      if (cpuReq === 1'b1) lat++;
      if ((|{selLowRam, selHighRam, selMod1, selMod2, selClock, selExt}) === 1'b1) begin
         seenTgt = accTarget;
         seenBe = byteEn;
      end
      if (cpuDone === 1'b1) begin
         cExp = cq.pop_front();
         check("latency", lat, cExp[4:2]);
         check("refused", cpuErr, cExp[5]);
         if (!cExp[5]) check("target lanes", {seenTgt, seenBe}, {cExp[8:6], cExp[1:0]});
         lat = 0;
         seenTgt = 3'h7;
      end
   end
   initial begin
      void'($urandom(32'h55e6626a));
      rst_for(20);
      wb(1'b0, `XPS_SEL_OFS, `XPS_SEL_RESET, 1'b0);
      wb(1'b0, 16'hF030, 32'h0000_0000, 1'b1);
      check("pins at reset", portPinFree, 4'hF);
      sweep(5'h05, 1'b0);
      $display("test reset_state done");
      for (int i = 0; i < 6; i++) begin
         rst_for(2);
         wb(1'b1, `XPS_SEL_OFS, 32'(sv[i]), 1'b0);
         wb(1'b1, `XPS_CFG_OFS, 32'h0000_0001, 1'b0);
         wb(1'b1, `XPS_SEL_OFS, 32'(~sv[i]), 1'b0);
         wb(1'b0, `XPS_SEL_OFS, 32'(sv[i]), 1'b0);
         check("pins free", portPinFree, {~sv[i][1], ~sv[i][0], ~sv[i][0], ~sv[i][1]});
         check("segment limit", segLimit, |sv[i][1:0]);
         sweep(sv[i], 1'b1);
         $display("test select %h done", sv[i]);
      end
      rst_for(2);
      wb(1'b1, `XPS_CFG_OFS, 32'h0000_0003, 1'b0);
      wb(1'b0, `XPS_SEL_OFS, 32'h0000_001F, 1'b0);
      sweep(5'h1F, 1'b1);
      $display("test emulation done");
      rst_for(2);
      wb(1'b1, `XPS_CFG_OFS, 32'h0000_0004, 1'b0);
      wb(1'b0, `XPS_SEL_OFS, 32'h0000_0005, 1'b0);
      check("osc stop clock off", oscStop, 1'b1);
      rst_for(2);
      wb(1'b1, `XPS_SEL_OFS, 32'h0000_0015, 1'b0);
      wb(1'b1, `XPS_CFG_OFS, 32'h0000_0005, 1'b0);
      wb(1'b0, `XPS_SEL_OFS, 32'h0000_0015, 1'b0);
      check("osc runs clock on", oscStop, 1'b0);
      wb(1'b1, `XPS_CFG_OFS, 32'h0000_000C, 1'b0);
      wb(1'b0, `XPS_SEL_OFS, 32'h0000_0015, 1'b0);
      check("osc stop by select", oscStop, 1'b1);
      $display("test power_down done");
      results();
   end
endmodule // tb
`default_nettype wire

//--- verification/xps_cpu_model.sv
// processor core model: issues one cpu access at a time to the decoder
// assumes the decoder answers every request with a cpuDone pulse
`timescale 1ns/10ps
`default_nettype none
module xps_cpu_model (
   input  wire logic        sys_clk,  // clock
   input  wire logic        cpuDone,  // completion
   output var  logic        cpuReq,   // request
   output var  logic [23:0] cpuAddr,  // address
   output var  logic        cpuWrite, // write
   output var  logic        cpuByte,  // byte access
   output var  logic        cpuBitOp, // bit access
   output var  logic        cpuStack  // stack access
);
   // idle values at time zero
   initial {cpuReq, cpuAddr, cpuWrite, cpuByte, cpuBitOp, cpuStack} = 29'h0000_0000;
   // ******************************************
   // access: f = {write, byte, bitop, stack}
   // ******************************************
   // held until done; released lines show the inverse
   task automatic access(input logic [23:0] a, input logic [3:0] f);
      @(posedge sys_clk);
      cpuReq <= 1'b1;
      cpuAddr <= a;
      {cpuWrite, cpuByte, cpuBitOp, cpuStack} <= f;
      do @(posedge sys_clk); while (cpuDone !== 1'b1);
      cpuReq <= 1'b0;
      cpuAddr <= ~a;
      {cpuWrite, cpuByte, cpuBitOp, cpuStack} <= ~f;
   endtask
endmodule // xps_cpu_model
`default_nettype wire

//--- verification/xps_periph_select_checker.sv
// port checker of the peripheral select decoder
// assumes one clock domain, bound onto xps_periph_select
`timescale 1ns/10ps
`default_nettype none
module xps_periph_select_checker (
   input wire logic        sys_clk,     // clock
   input wire logic        rst,         // sync reset
   input wire logic        wb_cyc_i,    // cycle
   input wire logic        wb_stb_i,    // strobe
   input wire logic        wb_ack_o,    // ack
   input wire logic        wb_err_o,    // error
   input wire logic [23:0] cpuAddr,     // address
   input wire logic        cpuByte,     // byte
   input wire logic        cpuBitOp,    // bit access
   input wire logic        cpuStack,    // stack access
   input wire logic        cpuDone,     // done
   input wire logic        cpuErr,      // refused
   input wire logic [2:0]  accTarget,   // target
   input wire logic        selLowRam,   // low ram
   input wire logic        selHighRam,  // high ram
   input wire logic        selMod1,     // module 1
   input wire logic        selMod2,     // module 2
   input wire logic        selClock,    // clock
   input wire logic        selExt,      // external
   input wire logic [1:0]  byteEn,      // lanes
   input wire logic [3:0]  portPinFree, // free pins
   input wire logic        segLimit     // four lines
);
   // ******************************************
   // assertions
   // ******************************************
   // one-hot image of the selects, ordered like the target codes
   wire logic [5:0] sels = {selClock, selMod2, selMod1, selHighRam, selLowRam, selExt};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_sel_matches_target: assert property ((|sels) |-> sels == 6'h01 << accTarget)
      else $error("selects disagree with target");
   a_ram_no_wait: assert property ($rose(selLowRam | selHighRam) && !cpuDone |=> cpuDone)
      else $error("ram access waited");
   a_module_two_waits: assert property ($rose(selMod1 | selMod2) |-> !cpuDone [*3] ##1 cpuDone)
      else $error("module access not two waits");
   a_refuse_cause: assert property (cpuErr |-> cpuDone && (cpuBitOp || cpuStack))
      else $error("refusal without cause");
   a_byte_lanes: assert property ((|sels) && !cpuErr |->
      byteEn == (cpuByte ? {cpuAddr[0], ~cpuAddr[0]} : 2'b11))
      else $error("byte lanes wrong");
   a_pin_pairs: assert property (portPinFree[0] == portPinFree[3] && portPinFree[1] == portPinFree[2])
      else $error("pins not paired");
   a_seg_limit_pins: assert property (segLimit == (portPinFree != 4'hF))
      else $error("segment limit off pins");
   a_done_pulse: assert property (cpuDone |=> !cpuDone)
      else $error("done longer than one cycle");
   a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
      else $error("wishbone request unanswered");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   c_module: cover property ($rose(selMod1));
   c_refused: cover property (cpuErr);
   c_unmapped: cover property (wb_err_o);
endmodule // xps_periph_select_checker
bind xps_periph_select xps_periph_select_checker u_chk (
   .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .cpuAddr(cpuAddr), .cpuByte(cpuByte),
   .cpuBitOp(cpuBitOp), .cpuStack(cpuStack), .cpuDone(cpuDone), .cpuErr(cpuErr),
   .accTarget(accTarget), .selLowRam(selLowRam), .selHighRam(selHighRam), .selMod1(selMod1),
   .selMod2(selMod2), .selClock(selClock), .selExt(selExt), .byteEn(byteEn),
   .portPinFree(portPinFree), .segLimit(segLimit));
`default_nettype wire
